/* core/wdcs_defines.svh */
// Purpose: Offsets, bit positions and reset values of the watchdog CSR
// Assumes: Word-addressed Avalon-MM slave, one 32-bit word per register
// Notes:   Definitions only
`ifndef WDCS_DEFINES_SVH
`define WDCS_DEFINES_SVH

`define WDCS_ADDR_W        4
`define WDCS_OFF_CSR       4'h0
`define WDCS_OFF_COUNTER   4'h1
`define WDCS_OFF_IRQ_STAT  4'h2
`define WDCS_OFF_IRQ_MASK  4'h3

`define WDCS_BIT_CWE_INH   7
`define WDCS_BIT_CWE       6
`define WDCS_BIT_SWE_INH   5
`define WDCS_BIT_SWE       4
`define WDCS_BIT_ON_INH    3
`define WDCS_BIT_ON        2
`define WDCS_BIT_FLAG_INH  1
`define WDCS_BIT_FLAG      0

`define WDCS_RST_CWE       1'h0
`define WDCS_RST_SWE       1'h0
`define WDCS_RST_ON        1'h0
`define WDCS_RST_FLAG      1'h0

`define WDCS_IRQ_BITS      2
`define WDCS_IRQ_OVF       0
`define WDCS_IRQ_REJECT    1

`endif

/* core/wdcs_pkg.sv */
// Purpose: Types shared by the watchdog CSR block
// Assumes: Nothing
// Notes:   Constants live in wdcs_defines.svh
package wdcs_pkg;

   typedef struct packed {
      logic       write;
      logic       read;
      logic [3:0] address;
      logic [3:0] byteenable;
      logic [31:0] writedata;
   } wdcs_req_t;

   typedef struct packed {
      logic        counter_write_enable;
      logic        status_write_enable;
      logic        watchdog_on;
      logic        watchdog_reset_flag;
   } wdcs_state_t;

endpackage

/* core/wdcs_sync.sv */
// Purpose: Two-stage synchroniser for a level from outside the clock domain
// Assumes: sys_clk domain
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
module wdcs_sync (
   input  wire logic sys_clk,
   input  wire logic reset,
   input  wire logic din,
   output logic      dout
);
   logic meta_reg;
   logic sync_reg;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end else begin
         meta_reg <= din;
         sync_reg <= meta_reg;
      end
   end

   assign dout = sync_reg;
endmodule

/* core/wdcs_top.sv */
// Purpose: Watchdog control/status register with per-bit write protection
// Assumes: Avalon-MM slave, one wait state per access, counter outside
// Notes:   reset is the external reset pin, already synchronous
//
// Design decisions made here: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`include "wdcs_defines.svh"
module wdcs_top
   import wdcs_pkg::*;
#(
   parameter int CNT_W = 8
) (
   input  wire logic                    sys_clk,
   input  wire logic                    reset,
   input  wire logic [`WDCS_ADDR_W-1:0] avs_address,
   input  wire logic                    avs_read,
   input  wire logic                    avs_write,
   input  wire logic [3:0]              avs_byteenable,
   input  wire logic [31:0]             avs_writedata,
   output logic      [31:0]             avs_readdata,
   output logic                         avs_waitrequest,
   input  wire logic                    wd_overflow_async,
   input  wire logic [CNT_W-1:0]        wd_count,
   output logic                         wd_count_we,
   output logic      [CNT_W-1:0]        wd_count_wdata,
   output logic                         wd_enable,
   output logic                         wd_irq
);

   wdcs_req_t   req;
   wdcs_state_t st_reg;
   wdcs_state_t st_next;

   logic        ack_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic        cnt_we_reg;
   logic [CNT_W-1:0] cnt_wdata_reg;
   logic [`WDCS_IRQ_BITS-1:0] stat_reg;
   logic [`WDCS_IRQ_BITS-1:0] stat_next;
   logic [`WDCS_IRQ_BITS-1:0] mask_reg;
   logic        ovf_sync;
   logic        ovf_d_reg;

   assign req.write      = avs_write;
   assign req.read       = avs_read;
   assign req.address    = avs_address;
   assign req.byteenable = avs_byteenable;
   assign req.writedata  = avs_writedata;

   wdcs_sync u_ovf_sync (
      .sys_clk (sys_clk),
      .reset   (reset),
      .din     (wd_overflow_async),
      .dout    (ovf_sync)
   );

   // One-cycle overflow event from the synchronised level
   wire ovf_evt = ovf_sync & ~ovf_d_reg;

   // Access completes on the cycle after it is first seen
   wire access   = (req.read | req.write) & ~ack_reg;
   // Writes take effect at the accept edge, when waitrequest is low
   wire wr_acc   = req.write & ack_reg & req.byteenable[0];
   wire hit_csr  = req.address == `WDCS_OFF_CSR;
   wire hit_cnt  = req.address == `WDCS_OFF_COUNTER;
   wire hit_stat = req.address == `WDCS_OFF_IRQ_STAT;
   wire hit_mask = req.address == `WDCS_OFF_IRQ_MASK;
   wire [7:0] wd = req.writedata[7:0];

   wire csr_wr   = wr_acc & hit_csr;
   wire cwe_upd  = csr_wr & ~wd[`WDCS_BIT_CWE_INH];
   wire swe_upd  = csr_wr & ~wd[`WDCS_BIT_SWE_INH];
   wire on_upd   = csr_wr & st_reg.status_write_enable
                 & ~wd[`WDCS_BIT_ON_INH];
   wire flag_upd = csr_wr & st_reg.status_write_enable
                 & ~wd[`WDCS_BIT_FLAG_INH];
   wire cnt_wr   = wr_acc & hit_cnt & st_reg.counter_write_enable;
   wire cnt_rej  = wr_acc & hit_cnt & ~st_reg.counter_write_enable;

   always_comb begin
      st_next = st_reg;
      if (cwe_upd) begin
         st_next.counter_write_enable = wd[`WDCS_BIT_CWE];
      end
      if (swe_upd) begin
         st_next.status_write_enable = wd[`WDCS_BIT_SWE];
      end
      if (on_upd) begin
         st_next.watchdog_on = wd[`WDCS_BIT_ON];
      end
      if (flag_upd) begin
         st_next.watchdog_reset_flag = wd[`WDCS_BIT_FLAG];
      end
      // Overflow wins over a simultaneous clearing write
      if (ovf_evt) begin
         st_next.watchdog_reset_flag = 1'b1;
      end
   end

   wire [7:0] csr_view = {1'b1, st_reg.counter_write_enable,
                          1'b1, st_reg.status_write_enable,
                          1'b1, st_reg.watchdog_on,
                          1'b1, st_reg.watchdog_reset_flag};

   // Set wins over write-one-to-clear
   wire [`WDCS_IRQ_BITS-1:0] irq_evt = {cnt_rej, ovf_evt};
   wire [`WDCS_IRQ_BITS-1:0] irq_clr =
      (wr_acc & hit_stat) ? req.writedata[`WDCS_IRQ_BITS-1:0]
                          : {`WDCS_IRQ_BITS{1'b0}};
   assign stat_next = (stat_reg & ~irq_clr) | irq_evt;

   always_comb begin
      rdata_next = 32'h0000_0000;
      if (hit_csr) begin
         rdata_next[7:0] = csr_view;
      end else if (hit_cnt) begin
         rdata_next[CNT_W-1:0] = wd_count;
      end else if (hit_stat) begin
         rdata_next[`WDCS_IRQ_BITS-1:0] = stat_reg;
      end else if (hit_mask) begin
         rdata_next[`WDCS_IRQ_BITS-1:0] = mask_reg;
      end
   end

   // The external reset pin clears the flag, as does a CSR write of 0 with the flag inhibit bit low while status writes are enabled
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st_reg.counter_write_enable <= `WDCS_RST_CWE;
         st_reg.status_write_enable  <= `WDCS_RST_SWE;
         st_reg.watchdog_on          <= `WDCS_RST_ON;
         st_reg.watchdog_reset_flag  <= `WDCS_RST_FLAG;
      end else begin
         st_reg <= st_next;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ack_reg   <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         ovf_d_reg <= 1'b0;
      end else begin
         ack_reg   <= access;
         ovf_d_reg <= ovf_sync;
         // Read data held until the next read is captured
         if (access & req.read) begin
            rdata_reg <= rdata_next;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         stat_reg <= {`WDCS_IRQ_BITS{1'b0}};
         mask_reg <= {`WDCS_IRQ_BITS{1'b0}};
      end else begin
         stat_reg <= stat_next;
         if (wr_acc & hit_mask) begin
            mask_reg <= req.writedata[`WDCS_IRQ_BITS-1:0];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cnt_we_reg    <= 1'b0;
         cnt_wdata_reg <= {CNT_W{1'b0}};
      end else begin
         cnt_we_reg <= cnt_wr;
         if (cnt_wr) begin
            cnt_wdata_reg <= req.writedata[CNT_W-1:0];
         end
      end
   end

   assign avs_waitrequest = (req.read | req.write) & ~ack_reg;
   assign avs_readdata    = rdata_reg;
   assign wd_count_we     = cnt_we_reg;
   assign wd_count_wdata  = cnt_wdata_reg;
   assign wd_enable       = st_reg.watchdog_on;
   assign wd_irq          = |(stat_reg & mask_reg);

endmodule

/* sim/wdcs_monitor.sv */
// Purpose: Port assertions for the watchdog CSR
// Assumes: One wait state per access
// Notes:   Bound into wdcs_top
`timescale 1ns/1ps
module wdcs_monitor #(parameter int CNT_W = 8) (
   input wire logic             sys_clk,
   input wire logic             reset,
   input wire logic [3:0]       avs_address,
   input wire logic             avs_read,
   input wire logic             avs_write,
   input wire logic [31:0]      avs_writedata,
   input wire logic [31:0]      avs_readdata,
   input wire logic             avs_waitrequest,
   input wire logic             wd_count_we,
   input wire logic [CNT_W-1:0] wd_count_wdata,
   input wire logic             wd_enable,
   input wire logic             wd_irq
);
   wire req   = avs_read | avs_write;
   wire wr_ok = avs_write & ~avs_waitrequest;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   a_wait_once: assert property (req & avs_waitrequest ##1 req
      |-> !avs_waitrequest) else $error("no answer");
   a_on_guard: assert property (!$past(reset) && $changed(wd_enable)
      |-> $past(wr_ok & avs_address == 4'h0 & ~avs_writedata[3])) else $error("on");
   a_on_value: assert property (!$past(reset) && $changed(wd_enable)
      |-> wd_enable == $past(avs_writedata[2])) else $error("on value");
   a_reset_clear: assert property ($past(reset)
      |-> !wd_enable && !wd_irq) else $error("reset");
   a_cnt_guard: assert property (wd_count_we
      |-> $past(wr_ok & avs_address == 4'h1)) else $error("count write");
   a_cnt_data: assert property (wd_count_we
      |-> wd_count_wdata == $past(avs_writedata[CNT_W-1:0])) else $error("data");
   a_we_pulse: assert property (wd_count_we
      |=> !wd_count_we) else $error("pulse");
   a_rdata_hold: assert property (!$past(req | reset)
      |-> $stable(avs_readdata)) else $error("read data");
   c_on: cover property ($rose(wd_enable));
   c_cnt: cover property (wd_count_we);
   c_irq: cover property ($rose(wd_irq));
endmodule
bind wdcs_top wdcs_monitor #(.CNT_W(CNT_W)) mon (.*);

/* sim/watchdog_control_status_tb.sv */
// Purpose: Self-checking bench for wdcs_top
// Assumes: Counter value tied, full byte lanes
// Notes:   Overflow level driven by the bench
`timescale 1ns/1ps
module watchdog_control_status_tb;
   logic        sys_clk = 0, reset = 1, avs_read = 0, avs_write = 0;
   logic        wd_overflow_async = 0, avs_waitrequest, wd_count_we;
   logic        wd_enable, wd_irq;
   logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'hF;
   logic [31:0] avs_writedata = 32'h0, avs_readdata;
   logic [7:0]  wd_count = 8'h3C, wd_count_wdata;
   int          fail_count = 0, cmp_count = 0, we_n = 0;
   wdcs_top uut (.*);
   always #2 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (wd_count_we) we_n <= we_n + 1;
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      fail_count += (seen !== exp);
      if (seen !== exp) $display("wrong value %0t: %h, %h", $time, seen, exp);
   endtask
   task test_done;
      $display("%0d compares, %0d wrong", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task acc(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      avs_write <= w;
      avs_read <= ~w;
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      repeat (20) begin
         @(posedge sys_clk);
         if (avs_waitrequest === 1'b0) break;
      end
      if (avs_waitrequest !== 1'b0) begin
         chk(avs_waitrequest, 0);
         test_done;
      end
      avs_write <= 0;
      avs_read <= 0;
   endtask
   task csr(input logic [7:0] d, input logic [7:0] exp);
      acc(1, 4'h0, d);
      acc(0, 4'h0, 8'h00);
      chk(avs_readdata, exp);
      chk(wd_enable, exp[2]);
   endtask
   task t_prot;
      csr(8'hAA, 8'hAA);
      csr(8'hA4, 8'hAA);
      csr(8'h90, 8'hBA);
      csr(8'hAC, 8'hBA);
      csr(8'hA6, 8'hBE);
      csr(8'hA2, 8'hBA);
      $display("protection test done");
   endtask
   task t_cnt_irq;
      acc(1, 4'h1, 8'h5A);
      acc(0, 4'h2, 8'h00);
      chk(avs_readdata, 32'h2);
      chk(we_n, 0);
      csr(8'h6A, 8'hFA);
      acc(1, 4'h1, 8'hC3);
      acc(0, 4'h1, 8'h00);
      chk(avs_readdata, 32'h3C);
      chk(we_n, 1);
      chk(wd_count_wdata, 8'hC3);
      acc(1, 4'h3, 8'h03);
      acc(0, 4'h7, 8'h00);
      chk(avs_readdata, 32'h0);
      chk(wd_irq, 1'b1);
      acc(1, 4'h2, 8'h02);
      acc(0, 4'h2, 8'h00);
      chk(wd_irq, 1'b0);
      $display("counter and interrupt test done");
   endtask
   task t_flag;
      wd_overflow_async <= 1'b1;
      repeat (6) @(posedge sys_clk);
      wd_overflow_async <= 1'b0;
      csr(8'hAA, 8'hFB);
      chk(wd_irq, 1'b1);
      csr(8'hA8, 8'hFA);
      wd_overflow_async <= 1'b1;
      repeat (6) @(posedge sys_clk);
      wd_overflow_async <= 1'b0;
      reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      csr(8'hAA, 8'hAA);
      chk(wd_irq, 1'b0);
      $display("flag test done");
   endtask
   initial begin
      repeat (8) @(posedge sys_clk);
      reset <= 0;
      t_prot;
      t_cnt_irq;
      t_flag;
      test_done;
   end
endmodule
